/* rtl/ppcr_pkg.sv */
package ppcr_pkg;
  localparam logic [15:0] PPCR_IDX_ROLE = 16'h1834;
  localparam logic [15:0] PPCR_IDX_TEST = 16'h1836;
  localparam logic [15:0] PPCR_IDX_PCS_CTRL = 16'h3000;
  localparam logic [15:0] PPCR_IDX_LPI_STAT = 16'h3001;
  localparam logic [17:0] PPCR_OFF_ROLE = 18'h060d0;
  localparam logic [17:0] PPCR_OFF_TEST = 18'h060d8;
  localparam logic [17:0] PPCR_OFF_PCS_CTRL = 18'h0c000;
  localparam logic [17:0] PPCR_OFF_LPI_STAT = 18'h0c004;
  localparam logic [17:0] PPCR_OFF_IRQ_STAT = 18'h10000;
  localparam logic [17:0] PPCR_OFF_IRQ_MASK = 18'h10004;
  localparam logic [15:0] PPCR_RST_ROLE = 16'h8000;
  localparam logic [15:0] PPCR_RST_TEST = 16'h0000;
  localparam logic [15:0] PPCR_RST_PCS_CTRL = 16'h0000;
  localparam int PPCR_BIT_MAN_EN = 15;
  localparam int PPCR_BIT_ROLE = 14;
  localparam int PPCR_TEST_HI = 15;
  localparam int PPCR_TEST_LO = 13;
  localparam int PPCR_BIT_PCS_RST = 15;
  localparam int PPCR_BIT_LOOP = 14;
  localparam int PPCR_BIT_RXSTOP = 10;
  localparam int PPCR_BIT_TX_LAT = 11;
  localparam int PPCR_BIT_RX_LAT = 10;
  localparam int PPCR_BIT_TX_NOW = 9;
  localparam int PPCR_BIT_RX_NOW = 8;
  localparam int PPCR_BIT_TXSTOP = 6;
  localparam logic [3:0] PPCR_PMA_TYPE = 4'h0;
  localparam logic [1:0] PPCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPCR_RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    PPCR_TM_NORMAL = 6'h01,
    PPCR_TM_MODE1 = 6'h02,
    PPCR_TM_MODE2 = 6'h04,
    PPCR_TM_MODE4 = 6'h08,
    PPCR_TM_MODE5 = 6'h10,
    PPCR_TM_RSVD = 6'h20
  } ppcr_tmode_t;
endpackage

/* rtl/ppcr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ppcr_sync
  import ppcr_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset.
  input wire logic clk_en, // Clock enable.
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised levels.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/ppcr_tmode_dec.sv */
`timescale 1ns/1ps
`default_nettype none
module ppcr_tmode_dec
  import ppcr_pkg::*;
(
  input wire logic [2:0] code, // Test mode field.
  output ppcr_tmode_t mode // Decoded test mode.
);
  always_comb
  begin
    case (code)
      3'h0: mode = PPCR_TM_NORMAL;
      3'h1: mode = PPCR_TM_MODE1;
      3'h2: mode = PPCR_TM_MODE2;
      3'h4: mode = PPCR_TM_MODE4;
      3'h5: mode = PPCR_TM_MODE5;
      default: mode = PPCR_TM_RSVD;
    endcase
  end
endmodule
`default_nettype wire

/* rtl/ppcr_regs.sv */
// How it works
// - Role control resets to 0x8000; manual-enable bit reads one, ignores writes.
// - Role select one means link master, zero means slave; read/write.
// - Role select loads from sampled strap at reset, chosen by package.
// - Four-bit type field reads zero, meaning 100BASE-T1.
// - Test mode field decodes normal, modes 1,2,4,5; others reserved.
// - Writing one to coding-layer reset resets, then bit reads zero.
// - Coding-layer reset restores coding registers and resets the core; here only loop and receive-stoppable bits are restored.
// - Loop enable is read/write, resets zero, cleared by coding reset.
// - Receive clock may stop during idle only when stoppable bit is one.
// - Transmit idle seen flag latches high until read.
// - Receive idle seen flag latches high until read.
// - Live bit shows transmit side currently receiving idle.
// - Live bit shows receive side currently receiving idle.
// - Transmit-clock-stoppable status bit is read-only; MAC obeys it.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ppcr_regs
  import ppcr_pkg::*;
(
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic pkg_small, // Strap package select, high for small package.
  input wire logic led0_bootstrap_input, // Role strap, large package.
  input wire logic rxdata3_bootstrap_input, // Role strap, small package.
  input wire logic transmit_idle_in, // Transmit side receiving idle, pin.
  input wire logic receive_idle_in, // Receive side receiving idle, pin.
  input wire logic tx_clk_stop_ok, // Core allows MAC to stop tx clock.
  input wire logic rx_idle_active, // Receive path is in low-power idle.
  input wire logic [17:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [17:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic link_master, // High when link master.
  output logic [2:0] test_mode, // Selected test mode code.
  output logic test_mode_reserved, // Reserved test mode selected.
  output logic core_reset, // One-cycle core reset pulse.
  output logic loop_enable, // Coding-layer loopback enable.
  output logic rx_clk_run, // Receive clock to MAC must run.
  output logic irq // Level interrupt.
);
  logic [1:0] idle_s;
  logic strap_done_q;
  logic [1:0] strap_wait_q;
  logic [2:0] strap_s;
  logic role_q;
  logic [15:0] test_q;
  logic loop_q;
  logic rxstop_q;
  logic pcs_rst_q;
  logic tx_lat_q;
  logic rx_lat_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic aw_have_q;
  logic w_have_q;
  logic [17:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  logic lat_clear;
  logic [15:0] rd_val;
  logic rd_hit;
  logic wr_hit;
  ppcr_tmode_t tmode;

  function automatic logic hit(input logic [17:0] a);
    hit = (a == PPCR_OFF_ROLE) || (a == PPCR_OFF_TEST) ||
      (a == PPCR_OFF_PCS_CTRL) || (a == PPCR_OFF_LPI_STAT) ||
      (a == PPCR_OFF_IRQ_STAT) || (a == PPCR_OFF_IRQ_MASK);
  endfunction

  ppcr_sync #(.WIDTH(5)) u_idle_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({pkg_small, led0_bootstrap_input, rxdata3_bootstrap_input,
      transmit_idle_in, receive_idle_in}),
    .sync_out({strap_s, idle_s})
  );

  ppcr_tmode_dec u_tmode (
    .code(test_q[PPCR_TEST_HI:PPCR_TEST_LO]),
    .mode(tmode)
  );

  // Write channel: address and data are taken in either order.
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit = hit(awaddr_q);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PPCR_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? PPCR_RESP_OKAY : PPCR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Strap is caught once the synchroniser has filled, never by reset.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
      role_q <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_wait_q <= {strap_wait_q[0], 1'b1};
      if (!strap_done_q && strap_wait_q[1])
      begin
        strap_done_q <= 1'b1;
        role_q <= strap_s[2] ? strap_s[0] : strap_s[1];
      end
      else if (wr_fire && awaddr_q == PPCR_OFF_ROLE && wstrb_q[1])
        role_q <= wdata_q[PPCR_BIT_ROLE];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      test_q <= PPCR_RST_TEST;
    else if (clk_en && wr_fire && awaddr_q == PPCR_OFF_TEST)
    begin
      if (wstrb_q[0])
        test_q[7:0] <= wdata_q[7:0];
      if (wstrb_q[1])
        test_q[15:8] <= wdata_q[15:8];
    end
  end

  // Reset bit self-clears one cycle after the write and is left out of the read data, so it always reads 0.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pcs_rst_q <= 1'b0;
      loop_q <= PPCR_RST_PCS_CTRL[PPCR_BIT_LOOP];
      rxstop_q <= PPCR_RST_PCS_CTRL[PPCR_BIT_RXSTOP];
    end
    else if (clk_en)
    begin
      pcs_rst_q <= 1'b0;
      if (pcs_rst_q)
      begin
        loop_q <= PPCR_RST_PCS_CTRL[PPCR_BIT_LOOP];
        rxstop_q <= PPCR_RST_PCS_CTRL[PPCR_BIT_RXSTOP];
      end
      else if (wr_fire && awaddr_q == PPCR_OFF_PCS_CTRL)
      begin
        if (wstrb_q[1])
        begin
          pcs_rst_q <= wdata_q[PPCR_BIT_PCS_RST];
          loop_q <= wdata_q[PPCR_BIT_LOOP];
          rxstop_q <= wdata_q[PPCR_BIT_RXSTOP];
        end
      end
    end
  end

  // Latched flags: a live condition beats the read clear.
  assign lat_clear = rd_fire && s_axi_araddr == PPCR_OFF_LPI_STAT;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_lat_q <= 1'b0;
      rx_lat_q <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_lat_q <= idle_s[1] | (tx_lat_q & ~lat_clear);
      rx_lat_q <= idle_s[0] | (rx_lat_q & ~lat_clear);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end
    else if (clk_en)
    begin
      if (wr_fire && awaddr_q == PPCR_OFF_IRQ_MASK && wstrb_q[0])
        irq_mask_q <= wdata_q[1:0];
      if (wr_fire && awaddr_q == PPCR_OFF_IRQ_STAT && wstrb_q[0])
        irq_stat_q <= (irq_stat_q & ~wdata_q[1:0]) | idle_s;
      else
        irq_stat_q <= irq_stat_q | idle_s;
    end
  end

  always_comb
  begin
    rd_val = 16'h0000;
    rd_hit = hit(s_axi_araddr);
    case (s_axi_araddr)
      PPCR_OFF_ROLE:
      begin
        rd_val[PPCR_BIT_MAN_EN] = PPCR_RST_ROLE[PPCR_BIT_MAN_EN];
        rd_val[PPCR_BIT_ROLE] = role_q;
        rd_val[3:0] = PPCR_PMA_TYPE;
      end
      PPCR_OFF_TEST: rd_val = test_q;
      PPCR_OFF_PCS_CTRL:
      begin
        rd_val[PPCR_BIT_LOOP] = loop_q;
        rd_val[PPCR_BIT_RXSTOP] = rxstop_q;
      end
      PPCR_OFF_LPI_STAT:
      begin
        rd_val[PPCR_BIT_TX_LAT] = tx_lat_q;
        rd_val[PPCR_BIT_RX_LAT] = rx_lat_q;
        rd_val[PPCR_BIT_TX_NOW] = idle_s[1];
        rd_val[PPCR_BIT_RX_NOW] = idle_s[0];
        rd_val[PPCR_BIT_TXSTOP] = tx_clk_stop_ok;
      end
      PPCR_OFF_IRQ_STAT: rd_val[1:0] = irq_stat_q;
      PPCR_OFF_IRQ_MASK: rd_val[1:0] = irq_mask_q;
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PPCR_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_val};
        s_axi_rresp <= rd_hit ? PPCR_RESP_OKAY : PPCR_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      link_master <= 1'b0;
      test_mode <= 3'h0;
      test_mode_reserved <= 1'b0;
      core_reset <= 1'b0;
      loop_enable <= 1'b0;
      rx_clk_run <= 1'b1;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      link_master <= role_q;
      test_mode <= test_q[PPCR_TEST_HI:PPCR_TEST_LO];
      test_mode_reserved <= (tmode == PPCR_TM_RSVD);
      core_reset <= pcs_rst_q;
      loop_enable <= loop_q;
      rx_clk_run <= !(rxstop_q && rx_idle_active);
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  a_role_reads_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_fire && s_axi_araddr == PPCR_OFF_ROLE |=> s_axi_rdata[15])
    else $error("manual enable bit read as zero");
  a_type_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_fire && s_axi_araddr == PPCR_OFF_ROLE |=> s_axi_rdata[3:0] == 4'h0)
    else $error("type field not zero");
  a_master_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en |=> link_master == $past(role_q))
    else $error("link master not following role");
  a_reset_selfclr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pcs_rst_q && clk_en |=> !pcs_rst_q)
    else $error("coding reset did not clear");
  a_loop_cleared: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pcs_rst_q && clk_en |=> !loop_q && !rxstop_q)
    else $error("loopback not cleared by reset");
  a_core_reset_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pcs_rst_q && clk_en |=> core_reset)
    else $error("core reset not pulsed");
  a_tx_lat_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tx_lat_q && !lat_clear && clk_en |=> tx_lat_q)
    else $error("transmit flag lost before read");
  a_rx_lat_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    idle_s[0] && clk_en |=> rx_lat_q)
    else $error("receive flag did not set");
  a_rx_clk_runs: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rxstop_q && clk_en |=> rx_clk_run)
    else $error("receive clock stopped while not stoppable");
  a_rsvd_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && test_q[15:13] == 3'h3 |=> test_mode_reserved)
    else $error("reserved test mode not flagged");
endmodule
`default_nettype wire

/* tb/ppcr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ppcr_host
(
  input wire logic clk_sys, // System clock.
  output logic [17:0] s_axi_awaddr, // Write address.
  output logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  output logic [31:0] s_axi_wdata, // Write data.
  output logic [3:0] s_axi_wstrb, // Write strobes.
  output logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Write response valid.
  output logic s_axi_bready, // Write response ready.
  output logic [17:0] s_axi_araddr, // Read address.
  output logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // Read response.
  input wire logic s_axi_rvalid, // Read data valid.
  output logic s_axi_rready // Read data ready.
);
  initial
  begin
    s_axi_awaddr = 18'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 18'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // Released payloads are inverted so a slave latching late sees junk.
  task automatic wr(input logic [17:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready && s_axi_awvalid) s_axi_awaddr <= ~a;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wdata <= ~v;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready && s_axi_arvalid) s_axi_araddr <= ~a;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/pma_pcs_control_status_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pma_pcs_control_status_regs_bench
  import ppcr_pkg::*;
;
  logic clk_sys, sys_rst, pkg_small, led0, rxd3, ti, ri, tso, ria, ce;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, link_master, test_mode_reserved;
  logic [2:0] test_mode;
  logic core_reset, loop_enable, rx_clk_run, irq, i0;
  int bad_count, n_tests, pulses, p;

  ppcr_regs ppcr_regs_inst
  (
    .clk_sys, .sys_rst, .clk_en(ce), .pkg_small,
    .led0_bootstrap_input(led0), .rxdata3_bootstrap_input(rxd3),
    .transmit_idle_in(ti), .receive_idle_in(ri), .tx_clk_stop_ok(tso),
    .rx_idle_active(ria), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_master, .test_mode,
    .test_mode_reserved, .core_reset, .loop_enable, .rx_clk_run, .irq
  );
  ppcr_host ppcr_host_inst
  (
    .clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (core_reset === 1'b1) pulses++;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [17:0] a, input logic [31:0] e);
    ppcr_host_inst.rd(a, d, r);
    chk({30'h0, r}, {30'h0, PPCR_RESP_OKAY});
    chk(d, e);
  endtask

  task automatic w(input logic [17:0] a, input logic [31:0] v);
    ppcr_host_inst.wr(a, v, r);
    chk({30'h0, r}, {30'h0, PPCR_RESP_OKAY});
  endtask

  task automatic t_reset();
    rchk(PPCR_OFF_ROLE, 32'hc000);
    rchk(PPCR_OFF_TEST, 32'h0);
    rchk(PPCR_OFF_PCS_CTRL, 32'h0);
    rchk(PPCR_OFF_LPI_STAT, 32'h0);
    rchk(PPCR_OFF_IRQ_STAT, 32'h0);
    @(negedge clk_sys);
    chk({31'h0, link_master}, 32'h1);
    chk({31'h0, rx_clk_run}, 32'h1);
  endtask

  // The small package must ignore the large package strap.
  task automatic t_strap();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    pkg_small <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rchk(PPCR_OFF_ROLE, 32'h8000);
    @(negedge clk_sys);
    chk({31'h0, link_master}, 32'h0);
  endtask

  task automatic t_role();
    w(PPCR_OFF_ROLE, 32'h0000400f);
    rchk(PPCR_OFF_ROLE, 32'hc000);
    @(negedge clk_sys);
    chk({31'h0, link_master}, 32'h1);
    w(PPCR_OFF_ROLE, 32'h0);
    rchk(PPCR_OFF_ROLE, 32'h8000);
    @(negedge clk_sys);
    chk({31'h0, link_master}, 32'h0);
    ppcr_host_inst.wr(18'h00008, 32'hffff, r);
    chk({30'h0, r}, {30'h0, PPCR_RESP_SLVERR});
    ppcr_host_inst.rd(18'h00008, d, r);
    chk({30'h0, r}, {30'h0, PPCR_RESP_SLVERR});
    chk(d, 32'h0);
  endtask

  task automatic t_test();
    for (int c = 0; c < 8; c++)
    begin
      w(PPCR_OFF_TEST, 32'(c) << 13);
      rchk(PPCR_OFF_TEST, 32'(c) << 13);
      @(negedge clk_sys);
      chk({29'h0, test_mode}, 32'(c));
      chk({31'h0, test_mode_reserved}, 32'(c == 3 || c > 5));
    end
  endtask

  task automatic t_pcs();
    @(posedge clk_sys);
    ria <= 1'b1;
    w(PPCR_OFF_PCS_CTRL, 32'h4400);
    rchk(PPCR_OFF_PCS_CTRL, 32'h4400);
    @(negedge clk_sys);
    chk({31'h0, loop_enable}, 32'h1);
    chk({31'h0, rx_clk_run}, 32'h0);
    p = pulses;
    w(PPCR_OFF_PCS_CTRL, 32'hc400);
    repeat (3) @(posedge clk_sys);
    chk(32'(pulses - p), 32'h1);
    rchk(PPCR_OFF_PCS_CTRL, 32'h0);
    @(negedge clk_sys);
    chk({31'h0, loop_enable}, 32'h0);
    chk({31'h0, rx_clk_run}, 32'h1);
    @(posedge clk_sys);
    ria <= 1'b0;
  endtask

  // A pulse on an idle pin while frozen must leave no trace.
  task automatic t_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    ti <= 1'b1;
    ri <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ti <= 1'b0;
    ri <= 1'b0;
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk(PPCR_OFF_LPI_STAT, 32'h0);
  endtask

  // Mask polarity is a design choice, so only the difference is judged.
  task automatic t_lpi();
    @(posedge clk_sys);
    tso <= 1'b1;
    ti <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ti <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rchk(PPCR_OFF_LPI_STAT, 32'h0840);
    rchk(PPCR_OFF_LPI_STAT, 32'h0040);
    @(posedge clk_sys);
    ti <= 1'b1;
    ri <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rchk(PPCR_OFF_LPI_STAT, 32'h0f40);
    rchk(PPCR_OFF_LPI_STAT, 32'h0f40);
    rchk(PPCR_OFF_IRQ_STAT, 32'h3);
    w(PPCR_OFF_IRQ_MASK, 32'h0);
    @(negedge clk_sys);
    i0 = irq;
    w(PPCR_OFF_IRQ_MASK, 32'h3);
    rchk(PPCR_OFF_IRQ_MASK, 32'h3);
    @(negedge clk_sys);
    chk({31'h0, i0 ^ irq}, 32'h1);
    @(posedge clk_sys);
    ti <= 1'b0;
    ri <= 1'b0;
    tso <= 1'b0;
    repeat (5) @(posedge clk_sys);
    w(PPCR_OFF_IRQ_STAT, 32'h3);
    rchk(PPCR_OFF_IRQ_STAT, 32'h0);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    w(PPCR_OFF_IRQ_MASK, 32'h0);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rchk(PPCR_OFF_LPI_STAT, 32'h0c00);
    rchk(PPCR_OFF_LPI_STAT, 32'h0);
  endtask

  initial
  begin
    #20000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    sys_rst = 1'b1;
    pkg_small = 1'b0;
    led0 = 1'b1;
    rxd3 = 1'b0;
    ti = 1'b0;
    ri = 1'b0;
    tso = 1'b0;
    ria = 1'b0;
    ce = 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_strap();
    t_role();
    t_test();
    t_pcs();
    t_lpi();
    t_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
